// ==== wstrg_trigger.sv ====
// wstrg_trigger: gathers pin, level-detect and boot triggers and launches the write sequencer.
// assumes the sequencer reports each executed step with its delay field, all on I_REF_CLK.
//
// Summary of operation
// - both general pins, used as inputs, can trigger the sequencer.
// - with a pin enabled, each rise or fall launches at that edge's index.
// - four 9-bit start indices, one per pin and edge.
// - a start index of 1FFh aborts the sequence instead of running it.
// - one enable per pin; software masks one edge by writing 1FFh.
// - pin two enable at bit 1, pin one at bit 0, both reset 0.
// - sequence memory contents survive hardware and software reset; undefined after power-on.
// - with level detect enabled, each rise or fall launches at its index.
// - only dynamics processor one's detect output triggers the sequencer.
// - separate 9-bit rise and fall detect indices, each resetting to 1FFh.
// - one detect enable; software masks one direction by writing 1FFh.
// - boot sequence runs after every reset.
// - boot always starts at index 384; 384 to 393 hold user boot steps.
// - writing 1 to bit 1 of the boot command launches boot anytime.
// - boot steps write factory trim values into control registers.
// - triggers during a run queue up; done flag raised when all finish.
// - a step with delay field Fh ends its sequence.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps

module wstrg_trigger
    import wstrg_pkg::*;
#(
    parameter int INDEX_WIDTH = IDX_W
) (
    input wire logic I_REF_CLK,
    input wire logic I_SYS_RST,
    input wire logic [ADDR_W-1:0] I_REG_ADDR,
    input wire logic [DATA_W-1:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [DATA_W-1:0] O_REG_RDATA,
    input wire logic I_PIN1,
    input wire logic I_PIN2,
    input wire logic I_LEVEL_DETECT,
    input wire wstrg_step_t I_STEP,
    output wstrg_req_t O_SEQ_REQ,
    output logic O_SEQ_BUSY,
    output logic O_SEQ_DONE
);

    // ==========================================================
    // elaboration check
    if (INDEX_WIDTH != IDX_W) begin : g_bad_width
        $error("wstrg_trigger: index width must be 9");
    end

    // ==========================================================
    // declarations
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } wstrg_state_t;

    wstrg_state_t state, next_state;
    logic [1:0] pin_meta, pin_sync, pin_prev;
    logic det_prev;
    logic [5:0] edge_evt;
    logic [2:0] trig_ena, next_trig_ena;
    logic [8:0] idx [0:5];
    logic [8:0] next_idx [0:5];
    logic [6:0] pending, next_pending;
    logic done, next_done;
    logic done_set;
    logic busy, next_busy;
    logic [8:0] cur_index, next_cur_index;
    wstrg_req_t req, next_req;
    logic [DATA_W-1:0] rdata, next_rdata;
    logic [2:0] pick;
    logic pick_any;
    logic last_step;
    logic [8:0] pick_index;

    // ==========================================================
    // helpers
    // lowest pending source wins; boot sits last of the edge sources
    function automatic logic [2:0] first_pending(input logic [6:0] p);
        logic [2:0] r;
        r = SRC_BOOT;
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
            if (p[k]) begin
                r = k[2:0];
            end
        end
        return r;
    endfunction

    // widen a 9-bit index to the read data width
    function automatic logic [DATA_W-1:0] widen_index(input logic [8:0] v);
        return {{(DATA_W - IDX_W){1'b0}}, v};
    endfunction

    // ==========================================================
    // pin synchronisers and edge detection
    // first stage read by the second stage only
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
            pin_prev <= 2'h0;
            det_prev <= 1'b0;
        end else begin
            pin_meta <= {I_PIN2, I_PIN1};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
            det_prev <= I_LEVEL_DETECT;
        end
    end

    // one pulse per edge, gated by the matching enable
    always_comb begin
        edge_evt[SRC_P1_RISE] = trig_ena[BIT_PIN1_ENA] & pin_sync[0] & ~pin_prev[0];
        edge_evt[SRC_P1_FALL] = trig_ena[BIT_PIN1_ENA] & ~pin_sync[0] & pin_prev[0];
        edge_evt[SRC_P2_RISE] = trig_ena[BIT_PIN2_ENA] & pin_sync[1] & ~pin_prev[1];
        edge_evt[SRC_P2_FALL] = trig_ena[BIT_PIN2_ENA] & ~pin_sync[1] & pin_prev[1];
        // only processor one's detect output is wired in
        edge_evt[SRC_DET_RISE] = trig_ena[BIT_DET_ENA] & I_LEVEL_DETECT & ~det_prev;
        edge_evt[SRC_DET_FALL] = trig_ena[BIT_DET_ENA] & ~I_LEVEL_DETECT & det_prev;
    end

    // ==========================================================
    // register writes
    // index registers hold start points only; sequence memory is never cleared here
    always_comb begin
        next_trig_ena = trig_ena;
        for (int k = 0; k < 6; k++) begin
            next_idx[k] = idx[k];
        end
        if (I_REG_WR) begin
            unique case (I_REG_ADDR)
                ADDR_PIN_ENA: next_trig_ena = I_REG_WDATA[2:0];
                ADDR_PIN1_RISE: next_idx[SRC_P1_RISE] = I_REG_WDATA[8:0];
                ADDR_PIN1_FALL: next_idx[SRC_P1_FALL] = I_REG_WDATA[8:0];
                ADDR_PIN2_RISE: next_idx[SRC_P2_RISE] = I_REG_WDATA[8:0];
                ADDR_PIN2_FALL: next_idx[SRC_P2_FALL] = I_REG_WDATA[8:0];
                ADDR_DET_RISE: next_idx[SRC_DET_RISE] = I_REG_WDATA[8:0];
                ADDR_DET_FALL: next_idx[SRC_DET_FALL] = I_REG_WDATA[8:0];
                default: begin
                end
            endcase
        end
    end

    // configuration flops; indices reset to the abort code
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            trig_ena <= 3'h0;
            for (int k = 0; k < 6; k++) begin
                idx[k] <= INDEX_RESET;
            end
        end else begin
            trig_ena <= next_trig_ena;
            for (int k = 0; k < 6; k++) begin
                idx[k] <= next_idx[k];
            end
        end
    end

    // ==========================================================
    // dispatcher
    // pending bits form the queue; a new edge beats the clear of the same bit
    always_comb begin
        pick = first_pending(pending);
        pick_any = |pending;
        pick_index = (pick == SRC_BOOT) ? BOOT_INDEX : idx[pick];
        last_step = I_STEP.valid && (I_STEP.delay == LAST_STEP_DELAY);
        next_state = state;
        next_pending = pending;
        next_busy = busy;
        next_cur_index = cur_index;
        next_req = '0;
        next_done = done;
        done_set = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (pick_any) begin
                    next_pending[pick] = 1'b0;
                    next_req.index = pick_index;
                    next_cur_index = pick_index;
                    if (pick_index == ABORT_INDEX) begin
                        next_req.abort = 1'b1;
                        done_set = ~|next_pending[5:0] & ~(pick != SRC_BOOT & pending[SRC_BOOT]);
                        next_done = done_set;
                    end else begin
                        next_req.start = 1'b1;
                        next_state = ST_RUN;
                        next_busy = 1'b1;
                    end
                end
            end
            ST_RUN: begin
                if (last_step) begin
                    next_state = ST_IDLE;
                    next_busy = 1'b0;
                    done_set = ~pick_any & ~|edge_evt;
                    next_done = done_set;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_busy = 1'b0;
            end
        endcase
        // software clears the done flag by writing 1; a fresh completion wins
        if (I_REG_WR && I_REG_ADDR == ADDR_SEQ_STATUS && I_REG_WDATA[BIT_DONE] && !done_set) begin
            next_done = 1'b0;
        end
        // any trigger starts a new round, so the done flag drops
        if (|edge_evt) begin
            next_done = 1'b0;
        end
        // new requests set pending bits after the clear above
        for (int k = 0; k < 6; k++) begin
            if (edge_evt[k]) begin
                next_pending[k] = 1'b1;
            end
        end
        if (I_REG_WR && I_REG_ADDR == ADDR_BOOT_CMD && I_REG_WDATA[BIT_BOOT_START]) begin
            next_pending[SRC_BOOT] = 1'b1;
            next_done = 1'b0;
        end
    end

    // dispatcher flops; reset leaves boot queued
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            state <= ST_IDLE;
            pending <= PENDING_RESET;
            busy <= 1'b0;
            done <= 1'b0;
            cur_index <= 9'h000;
            req <= '0;
        end else begin
            state <= next_state;
            pending <= next_pending;
            busy <= next_busy;
            done <= next_done;
            cur_index <= next_cur_index;
            req <= next_req;
        end
    end

    // ==========================================================
    // register reads, data valid in the cycle after the strobe only
    always_comb begin
        next_rdata = '0;
        if (I_REG_RD) begin
            unique case (I_REG_ADDR)
                ADDR_BOOT_CMD: next_rdata[BIT_BOOT_START] = pending[SRC_BOOT];
                ADDR_SEQ_STATUS: begin
                    next_rdata[BIT_BUSY] = busy;
                    next_rdata[BIT_DONE] = done;
                    next_rdata[BIT_CUR_LSB +: IDX_W] = cur_index;
                end
                ADDR_PIN_ENA: next_rdata[2:0] = trig_ena;
                ADDR_PIN1_RISE: next_rdata = widen_index(idx[SRC_P1_RISE]);
                ADDR_PIN1_FALL: next_rdata = widen_index(idx[SRC_P1_FALL]);
                ADDR_PIN2_RISE: next_rdata = widen_index(idx[SRC_P2_RISE]);
                ADDR_PIN2_FALL: next_rdata = widen_index(idx[SRC_P2_FALL]);
                ADDR_DET_RISE: next_rdata = widen_index(idx[SRC_DET_RISE]);
                ADDR_DET_FALL: next_rdata = widen_index(idx[SRC_DET_FALL]);
                default: next_rdata = '0;
            endcase
        end
    end

    // read data flop
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ==========================================================
    // outputs, all straight from flops
    assign O_REG_RDATA = rdata;
    assign O_SEQ_REQ = req;
    assign O_SEQ_BUSY = busy;
    assign O_SEQ_DONE = done;

    // ==========================================================
    // checks
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_SYS_RST);

    chk_boot_after_reset: assert property (
        $fell(I_SYS_RST) |-> ##[0:1] (O_SEQ_REQ.start && O_SEQ_REQ.index == 9'h180)
    ) else $error("boot not launched after reset");

    chk_abort_code: assert property (
        O_SEQ_REQ.start |-> O_SEQ_REQ.index != 9'h1ff
    ) else $error("start issued with abort index");

    chk_abort_index: assert property (
        O_SEQ_REQ.abort |-> (O_SEQ_REQ.index == 9'h1ff && !O_SEQ_REQ.start)
    ) else $error("abort issued with a runnable index");

    chk_pin1_rise: assert property (
        (trig_ena[0] && pin_sync[0] && !pin_prev[0] && !busy && pending == 7'h00)
            |=> ##1 (O_SEQ_REQ.index == $past(idx[0]) && (O_SEQ_REQ.start || O_SEQ_REQ.abort))
    ) else $error("pin one rise not launched at its index");

    chk_pin_disabled: assert property (
        (!trig_ena[1] && pin_sync[1] != pin_prev[1]) |-> !edge_evt[2] && !edge_evt[3]
    ) else $error("disabled pin raised a request");

    chk_boot_cmd: assert property (
        (I_REG_WR && I_REG_ADDR == 8'h18 && I_REG_WDATA[1]) |=> pending[6] || O_SEQ_REQ.start
    ) else $error("boot command lost");

    chk_last_step: assert property (
        (state == ST_RUN && I_STEP.valid && I_STEP.delay == 4'hf) |=> !O_SEQ_BUSY ##1 1'b1
    ) else $error("sequence did not end on last step");

    chk_no_overlap: assert property (
        O_SEQ_BUSY |-> !O_SEQ_REQ.start ##1 1'b1 or $rose(O_SEQ_BUSY)
    ) else $error("second sequence launched while running");

    chk_queue_drains: assert property (
        ($fell(O_SEQ_BUSY) && pending != 7'h00) |=> (O_SEQ_REQ.start || O_SEQ_REQ.abort)
    ) else $error("queued request not dispatched");

    chk_edge_once: assert property (
        edge_evt[2] |=> !edge_evt[2]
    ) else $error("one pin edge gave two requests");

    chk_det_index: assert property (
        (trig_ena[2] && I_LEVEL_DETECT && !det_prev && !busy && pending == 7'h00)
            |=> ##1 (O_SEQ_REQ.index == $past(idx[4]) && (O_SEQ_REQ.start || O_SEQ_REQ.abort))
    ) else $error("detect rise not launched at its index");

endmodule

// ==== wstrg_pkg.sv ====
// wstrg_pkg: constants and carrier types for the sequencer trigger block.
// assumes one 50 MHz system clock and a 16-bit register port with 8-bit offsets.
package wstrg_pkg;

    // ==========================================================
    // widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int IDX_W = 9;
    localparam int DELAY_W = 4;
    localparam int NUM_SRC = 7;            // six edge sources plus boot
    localparam int SRC_W = 3;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_BOOT_CMD = 8'h18;
    localparam logic [7:0] ADDR_SEQ_STATUS = 8'h19;
    localparam logic [7:0] ADDR_PIN_ENA = 8'h41;
    localparam logic [7:0] ADDR_PIN1_RISE = 8'h68;
    localparam logic [7:0] ADDR_PIN1_FALL = 8'h69;
    localparam logic [7:0] ADDR_PIN2_RISE = 8'h6a;
    localparam logic [7:0] ADDR_PIN2_FALL = 8'h6b;
    localparam logic [7:0] ADDR_DET_RISE = 8'h6e;
    localparam logic [7:0] ADDR_DET_FALL = 8'h6f;

    // ==========================================================
    // field positions
    localparam int BIT_BOOT_START = 1;
    localparam int BIT_PIN1_ENA = 0;
    localparam int BIT_PIN2_ENA = 1;
    localparam int BIT_DET_ENA = 2;
    localparam int BIT_BUSY = 0;
    localparam int BIT_DONE = 1;
    localparam int BIT_CUR_LSB = 2;

    // ==========================================================
    // source numbering, reset values and special codes
    localparam logic [2:0] SRC_P1_RISE = 3'h0;
    localparam logic [2:0] SRC_P1_FALL = 3'h1;
    localparam logic [2:0] SRC_P2_RISE = 3'h2;
    localparam logic [2:0] SRC_P2_FALL = 3'h3;
    localparam logic [2:0] SRC_DET_RISE = 3'h4;
    localparam logic [2:0] SRC_DET_FALL = 3'h5;
    localparam logic [2:0] SRC_BOOT = 3'h6;
    localparam logic [8:0] INDEX_RESET = 9'h1ff;
    localparam logic [8:0] ABORT_INDEX = 9'h1ff;
    localparam logic [8:0] BOOT_INDEX = 9'h180;
    localparam logic [3:0] LAST_STEP_DELAY = 4'hf;
    localparam logic [6:0] PENDING_RESET = 7'h40;    // boot queued out of reset

    // ==========================================================
    // carrier types
    typedef struct packed {
        logic start;           // one-cycle launch pulse
        logic abort;           // one-cycle abort pulse
        logic [8:0] index;     // start index of the launched sequence
    } wstrg_req_t;

    typedef struct packed {
        logic valid;           // one step executed
        logic [3:0] delay;     // delay field of that step
    } wstrg_step_t;

endpackage

// ==== wstrg_seq_model.sv ====
// wstrg_seq_model: behavioural write sequencer that answers launch pulses with step reports.
// assumes launch pulses on the shared rising clock edge; i_slow stretches the gap between steps.
`timescale 1ns/1ps

module wstrg_seq_model
    import wstrg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire wstrg_req_t i_req,
    input wire logic i_slow,
    output wstrg_step_t o_step
);
    logic [1:0] left;
    logic [4:0] gap;

    // ==========================================================
    // step timing: three steps per sequence, the last one carries the end marker
    always @(posedge i_clk) begin
        o_step.valid <= 1'b0;
        o_step.delay <= o_step.delay + 4'h5; // idle delay field keeps changing
        if (i_rst) begin
            left <= 2'h0;
            gap <= 5'h0;
            o_step.delay <= 4'h0;
        end else if (i_req.start) begin // clock runs throughout
            left <= 2'h3;
            gap <= i_slow ? 5'h14 : 5'h1;
        end else if (left != 2'h0) begin
            if (gap == 5'h0) begin
                o_step.valid <= 1'b1;
                o_step.delay <= (left == 2'h1) ? LAST_STEP_DELAY : 4'h0;
                left <= left - 2'h1;
                gap <= i_slow ? 5'h14 : 5'h1;
            end else begin
                gap <= gap - 5'h1;
            end
        end
    end
endmodule

// ==== wstrg_testbench.sv ====
// testbench: self-checking bench for the sequencer trigger block with a sequencer model.
// assumes a 50 MHz clock, synchronous active-high reset and one-cycle register strobes.
`timescale 1ns/1ps

module testbench
    import wstrg_pkg::*;
;
    logic ref_clk, sys_rst, reg_wr, reg_rd, pin1, pin2, level_detect, slow, rd_seen;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    wstrg_step_t step;
    wstrg_req_t seq_req;
    logic seq_busy, seq_done;
    logic [10:0] req_q[$];
    logic [15:0] rd_q[$];
    logic [8:0] idx[6];
    int error_cnt = 0;
    int checks = 0;
    const logic [7:0] addr_tab[6] = '{ADDR_PIN1_RISE, ADDR_PIN1_FALL, ADDR_PIN2_RISE, ADDR_PIN2_FALL,
                                      ADDR_DET_RISE, ADDR_DET_FALL};

    wstrg_trigger i_wstrg_trigger (.I_REF_CLK(ref_clk), .I_SYS_RST(sys_rst), .I_REG_ADDR(reg_addr),
        .I_REG_WDATA(reg_wdata), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .O_REG_RDATA(reg_rdata),
        .I_PIN1(pin1), .I_PIN2(pin2), .I_LEVEL_DETECT(level_detect), .I_STEP(step),
        .O_SEQ_REQ(seq_req), .O_SEQ_BUSY(seq_busy), .O_SEQ_DONE(seq_done));
    wstrg_seq_model i_wstrg_seq_model (.i_clk(ref_clk), .i_rst(sys_rst), .i_req(seq_req), .i_slow(slow),
        .o_step(step));

    // ==========================================================
    // clock and helpers
    // fixed frequency for the whole run, boot steps never retune it
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        rd_q.push_back(exp);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask

    // note a launch (abort=0) or abort (abort=1) at the given index
    task automatic expect_req(input logic ab, input logic [8:0] ix);
        req_q.push_back({~ab, ab, ix});
    endtask

    task automatic wait_idle();
        int i;
        for (i = 0; i < 3000 && (seq_busy !== 1'b0 || req_q.size() != 0); i++)
            @(posedge ref_clk);
        if (i == 3000)
            check("idle wait", 16'h1, 16'h0);
        repeat (4) @(posedge ref_clk);
    endtask

    // ==========================================================
    // monitor: compares read data and launches against the oldest note
    always @(posedge ref_clk) rd_seen <= reg_rd;
    always @(negedge ref_clk) begin
        if (rd_seen === 1'b1) begin
            if (rd_q.size() == 0) check("read note", 16'h1, 16'h0);
            else check("read data", reg_rdata, rd_q.pop_front());
        end
        if (sys_rst === 1'b0 && (seq_req.start === 1'b1 || seq_req.abort === 1'b1)) begin
            if (req_q.size() == 0) check("request note", 16'h1, 16'h0);
            else check("request", {5'h0, seq_req}, {5'h0, req_q.pop_front()});
        end
    end

    // ==========================================================
    // watchdog
    initial begin
        repeat (60000) @(posedge ref_clk);
        error_cnt++;
        stop_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'hca7c));
        {sys_rst, reg_wr, reg_rd, pin1, pin2, level_detect, slow} = 7'h40;
        reg_addr = 8'h0;
        reg_wdata = 16'h0;
        expect_req(1'b0, BOOT_INDEX);
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wait_idle();
        check("done flag", {15'h0, seq_done}, 16'h1);
        // status shows the boot index; writing 1 to done clears it
        rd(ADDR_SEQ_STATUS, {5'h0, BOOT_INDEX, 2'h2});
        wr(ADDR_SEQ_STATUS, 16'h0002);
        @(posedge ref_clk);
        check("done cleared", {15'h0, seq_done}, 16'h0);
        // reset values and an unmapped offset
        rd(ADDR_PIN_ENA, 16'h0);
        rd(ADDR_BOOT_CMD, 16'h0);
        rd(8'h55, 16'h0);
        for (int k = 0; k < 6; k++) rd(addr_tab[k], 16'h01ff);
        // program indices within the runnable range
        for (int k = 0; k < 6; k++) begin
            idx[k] = 9'($urandom_range(509));
            wr(addr_tab[k], {7'h0, idx[k]});
            rd(addr_tab[k], {7'h0, idx[k]});
        end
        wr(ADDR_PIN_ENA, 16'h0003);
        rd(ADDR_PIN_ENA, 16'h0003);
        // each pin and edge launches at its own index
        for (int k = 0; k < 4; k++) begin
            expect_req(1'b0, idx[k]);
            @(posedge ref_clk);
            if (k < 2) pin1 <= (k == 0);
            else pin2 <= (k == 2);
            wait_idle();
        end
        // masked falling edge gives an abort
        wr(ADDR_PIN1_FALL, 16'h01ff);
        expect_req(1'b0, idx[0]);
        @(posedge ref_clk) pin1 <= 1'b1;
        wait_idle();
        expect_req(1'b1, ABORT_INDEX);
        @(posedge ref_clk) pin1 <= 1'b0;
        wait_idle();
        check("done after abort", {15'h0, seq_done}, 16'h1);
        // disabled pin stays silent
        wr(ADDR_PIN_ENA, 16'h0000);
        @(posedge ref_clk) pin2 <= 1'b1;
        repeat (10) @(posedge ref_clk);
        pin2 <= 1'b0;
        wait_idle();
        // level detect both directions
        wr(ADDR_PIN_ENA, 16'h0004);
        expect_req(1'b0, idx[4]);
        @(posedge ref_clk) level_detect <= 1'b1;
        wait_idle();
        expect_req(1'b0, idx[5]);
        @(posedge ref_clk) level_detect <= 1'b0;
        wait_idle();
        // boot command, then two triggers queued during the run
        slow <= 1'b1;
        wr(ADDR_PIN_ENA, 16'h0007);
        wr(ADDR_PIN1_FALL, {7'h0, idx[1]});
        expect_req(1'b0, BOOT_INDEX);
        wr(ADDR_BOOT_CMD, 16'h0002);
        repeat (8) @(posedge ref_clk);
        check("busy in boot", {15'h0, seq_busy}, 16'h1);
        expect_req(1'b0, idx[0]);
        expect_req(1'b0, idx[4]);
        level_detect <= 1'b1;
        pin1 <= 1'b1;
        wait_idle();
        slow <= 1'b0;
        // reset in mid-run queues boot again and clears the map
        expect_req(1'b0, idx[5]);
        @(posedge ref_clk) level_detect <= 1'b0;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b1;
        expect_req(1'b0, BOOT_INDEX);
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wait_idle();
        rd(ADDR_PIN_ENA, 16'h0);
        rd(ADDR_PIN2_RISE, 16'h01ff);
        repeat (3) @(posedge ref_clk);
        check("pending notes", 16'(req_q.size() + rd_q.size()), 16'h0);
        stop_test();
    end
endmodule
